// ### include/sram_ctrl_pkg.sv
package sram_ctrl_pkg;
	localparam int ADDR_W     = 17;
	localparam int DATA_W     = 32;
	localparam int LANES      = 4;
	localparam int LANE_W     = 8;
	localparam int FIFO_DEPTH = 4;
	localparam int BEAT_W     = 2;
	localparam int ENTRY_W    = LANES + ADDR_W + DATA_W;

	localparam logic [LANES-1:0]  MASK_ALL   = 4'hF;
	localparam logic [LANES-1:0]  MASK_NONE  = 4'h0;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_STEP  = 2'h1;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FIRST = 3'b010,
		ST_BURST = 3'b100
	} burst_state_e;
endpackage : sram_ctrl_pkg

// ### rtl/burst_sram_ctrl.sv
// Contract
// - All inputs sampled on rising edge except output enable, burst order, sleep.
// - Read starts on strobe low, all enables active, no write requested.
// - Processor strobe ignored while first chip enable is high.
// - Read data registered and driven after the next rising edge.
// - First cycle after becoming selected keeps data outputs floating.
// - Strobe with enables inactive floats data outputs immediately.
// - Processor-strobe start ignores write controls and advance in first cycle.
// - Processor-strobe write takes two cycles; controls and data at second edge.
// - Global write low at second edge writes whole word.
// - Otherwise write only low byte selects, only while byte write enable low.
// - Global write overrides byte write enable and byte selects.
// - Controller-strobe write completes in one cycle at sampled address.
// - Controller-strobe write ignores advance; byte or full per controls.
// - Sleep input forces power-down, contents kept.
// - Strobed cycle with any enable inactive is not selected, no access.
// - Strobes high: advance low steps burst, high holds as wait state; code ignores advance on the second-cycle processor-strobe write.
// - Burst order high: low address bits are start XOR beat.
// - Write cycle when controls request a write, read cycle otherwise.
// - Output enable gates data drivers without the clock.
// - Accepted strobe registers address, low two bits start burst counter.
`timescale 1ns/100ps
`default_nettype none
module burst_sram_ctrl
	import sram_ctrl_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic              core_clk_i,
	input  wire logic              resetn_i,
	input  wire logic [AW-1:0]     addr_i,
	input  wire logic              proc_addr_strobe_n_i,
	input  wire logic              ctrl_addr_strobe_n_i,
	input  wire logic              burst_advance_n_i,
	input  wire logic              chip_sel_first_n_i,
	input  wire logic              chip_sel_second_hi_i,
	input  wire logic              chip_sel_third_n_i,
	input  wire logic              global_write_n_i,
	input  wire logic              byte_write_enable_n_i,
	input  wire logic              lane_a_write_n_i,
	input  wire logic              lane_b_write_n_i,
	input  wire logic              lane_c_write_n_i,
	input  wire logic              lane_d_write_n_i,
	input  wire logic              output_enable_n_i,
	input  wire logic              burst_order_i,
	input  wire logic              sleep_request_i,
	input  wire logic [DATA_W-1:0] dq_i,
	output logic [DATA_W-1:0]      dq_o,
	output logic                   dq_oe_o
);
	localparam int EW = LANES + AW + DATA_W;

	function automatic logic [LANES-1:0] write_mask(input logic gw_n, input logic bwe_n,
		input logic [LANES-1:0] lanes_n);
		if (!gw_n) begin
			write_mask = MASK_ALL;
		end else if (!bwe_n) begin
			write_mask = ~lanes_n;
		end else begin
			write_mask = MASK_NONE;
		end
	endfunction : write_mask

	function automatic logic [BEAT_W-1:0] burst_low(input logic [BEAT_W-1:0] start,
		input logic [BEAT_W-1:0] beat, input logic interleaved);
		burst_low = interleaved ? (start ^ beat) : (start + beat);
	endfunction : burst_low

	function automatic logic [DATA_W-1:0] merge_lanes(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic [LANES-1:0] mask);
		merge_lanes = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (mask[i]) begin
				merge_lanes[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
	endfunction : merge_lanes

	logic [DATA_W-1:0] mem [2**AW];

	burst_state_e      state_reg, state_next;
	logic [AW-1:0]     addr_reg, addr_next;
	logic [BEAT_W-1:0] start_reg, start_next;
	logic [BEAT_W-1:0] beat_reg, beat_next;
	logic              rd_pend_reg, rd_pend_next;
	logic              drive_reg, drive_next;
	logic [DATA_W-1:0] out_reg, out_next;
	logic              sleep_meta_reg, sleep_sync_reg;
	logic              order_meta_reg, order_sync_reg;

	logic [LANES-1:0]  lanes_n, push_mask;
	logic              ce_ok, proc_go, strobe, wr_req;
	logic [AW-1:0]     cur_addr, push_addr;
	logic              push_valid, fifo_in_ready, fifo_out_valid;
	logic [EW-1:0]     fifo_out;
	logic [LANES-1:0]  head_mask;
	logic [AW-1:0]     head_addr;
	logic [DATA_W-1:0] head_data, array_word;

	// Sleep and burst order pins pass two stages
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sleep_meta_reg <= 1'b0;
			sleep_sync_reg <= 1'b0;
			order_meta_reg <= 1'b0;
			order_sync_reg <= 1'b0;
		end else begin
			sleep_meta_reg <= sleep_request_i;
			sleep_sync_reg <= sleep_meta_reg;
			order_meta_reg <= burst_order_i;
			order_sync_reg <= order_meta_reg;
		end
	end

	always_comb begin
		lanes_n   = {lane_d_write_n_i, lane_c_write_n_i, lane_b_write_n_i, lane_a_write_n_i};
		ce_ok     = !chip_sel_first_n_i && chip_sel_second_hi_i && !chip_sel_third_n_i;
		proc_go   = !proc_addr_strobe_n_i && !chip_sel_first_n_i;
		strobe    = proc_go || !ctrl_addr_strobe_n_i;
		push_mask = write_mask(global_write_n_i, byte_write_enable_n_i, lanes_n);
		wr_req    = push_mask != MASK_NONE;
		cur_addr  = {addr_reg[AW-1:BEAT_W], burst_low(start_reg, beat_reg, order_sync_reg)};
		{head_mask, head_addr, head_data} = fifo_out;
		array_word = mem[cur_addr];
		if (fifo_out_valid && head_addr == cur_addr) begin
			array_word = merge_lanes(array_word, head_data, head_mask);
		end
	end

	always_comb begin
		state_next   = state_reg;
		addr_next    = addr_reg;
		start_next   = start_reg;
		beat_next    = beat_reg;
		rd_pend_next = 1'b0;
		drive_next   = rd_pend_reg;
		out_next     = rd_pend_reg ? array_word : out_reg;
		push_valid   = 1'b0;
		push_addr    = cur_addr;
		if (sleep_sync_reg) begin
			state_next = ST_IDLE;
			drive_next = 1'b0;
		end else if (strobe) begin
			if (!ce_ok) begin
				state_next = ST_IDLE;
				drive_next = 1'b0;
			end else begin
				addr_next  = addr_i;
				start_next = addr_i[BEAT_W-1:0];
				beat_next  = BEAT_FIRST;
				if (proc_go) begin
					state_next   = ST_FIRST;
					rd_pend_next = 1'b1;
				end else if (wr_req) begin
					state_next = ST_BURST;
					push_valid = fifo_in_ready;
					push_addr  = addr_i;
				end else begin
					state_next   = ST_BURST;
					rd_pend_next = 1'b1;
				end
			end
		end else if (state_reg != ST_IDLE) begin
			state_next = ST_BURST;
			if (state_reg == ST_FIRST && wr_req) begin
				push_valid = fifo_in_ready;
				drive_next = 1'b0;
			end else begin
				if (!burst_advance_n_i) begin
					beat_next = beat_reg + BEAT_STEP;
				end
				push_addr = {addr_reg[AW-1:BEAT_W], burst_low(start_reg, beat_next,
					order_sync_reg)};
				push_valid   = wr_req && fifo_in_ready;
				rd_pend_next = !wr_req;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_reg   <= ST_IDLE;
			addr_reg    <= '0;
			start_reg   <= '0;
			beat_reg    <= '0;
			rd_pend_reg <= 1'b0;
			drive_reg   <= 1'b0;
			out_reg     <= '0;
		end else begin
			state_reg   <= state_next;
			addr_reg    <= addr_next;
			start_reg   <= start_next;
			beat_reg    <= beat_next;
			rd_pend_reg <= rd_pend_next;
			drive_reg   <= drive_next;
			out_reg     <= out_next;
		end
	end

	// Writes queue and retire on their own; stalled while asleep
	write_fifo #(
		.WIDTH(EW),
		.DEPTH(FIFO_DEPTH)
	) u_write_fifo (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.in_valid_i (push_valid),
		.in_ready_o (fifo_in_ready),
		.in_data_i  ({push_mask, push_addr, dq_i}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(!sleep_sync_reg),
		.out_data_o (fifo_out)
	);

	always_ff @(posedge core_clk_i) begin
		if (fifo_out_valid && !sleep_sync_reg) begin
			mem[head_addr] <= merge_lanes(mem[head_addr], head_data, head_mask);
		end
	end

	assign dq_o    = out_reg;
	assign dq_oe_o = drive_reg && !output_enable_n_i;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence ctrl_read_s;
		!ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && ce_ok && !wr_req && !sleep_sync_reg;
	endsequence
	sequence stay_selected_s;
		!sleep_sync_reg && !(strobe && !ce_ok);
	endsequence
	sequence proc_start_s;
		proc_go && ce_ok && !sleep_sync_reg;
	endsequence
	sequence proc_second_wr_s;
		proc_addr_strobe_n_i && ctrl_addr_strobe_n_i && wr_req && !sleep_sync_reg
			&& fifo_in_ready && !fifo_out_valid;
	endsequence

	read_latency_a: assert property (ctrl_read_s ##1 stay_selected_s |=> drive_reg && dq_o == $past(array_word))
		else $error("read data not driven one cycle after the access");
	desel_float_a: assert property (strobe && !ce_ok && !sleep_sync_reg |=> !drive_reg && state_reg == ST_IDLE)
		else $error("deselect did not float outputs");
	first_float_a: assert property ($past(state_reg == ST_IDLE) && state_reg != ST_IDLE |-> !drive_reg)
		else $error("outputs driven in first selected cycle");
	strobe_ignored_a: assert property (chip_sel_first_n_i && ctrl_addr_strobe_n_i && state_reg == ST_IDLE |=> state_reg == ST_IDLE)
		else $error("processor strobe honoured with first enable high");
	first_no_write_a: assert property (proc_start_s |-> !push_valid ##1 state_reg == ST_FIRST)
		else $error("write accepted in first processor cycle");
	proc_write_a: assert property (proc_start_s ##1 proc_second_wr_s |=> fifo_out_valid && head_addr == $past(addr_i, 2) && head_data == $past(dq_i))
		else $error("processor write not at registered address");
	ctrl_write_a: assert property (!ctrl_addr_strobe_n_i && proc_addr_strobe_n_i && ce_ok && wr_req && !sleep_sync_reg && !fifo_out_valid |=> fifo_out_valid && head_addr == $past(addr_i))
		else $error("controller write not queued at sampled address");
	global_mask_a: assert property (push_valid && !global_write_n_i && !fifo_out_valid |=> head_mask == MASK_ALL)
		else $error("global write did not cover every lane");
	wait_state_a: assert property (state_reg == ST_BURST && !strobe && burst_advance_n_i && !sleep_sync_reg |=> $stable(beat_reg))
		else $error("wait state moved the burst counter");
	sleep_quiet_a: assert property (sleep_sync_reg [*2] |-> !drive_reg && state_reg == ST_IDLE)
		else $error("device active while asleep");
endmodule : burst_sram_ctrl
`default_nettype wire

// ### rtl/write_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module write_fifo #(
	parameter int WIDTH = 53,
	parameter int DEPTH = 4
) (
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0]    count_reg, count_next;
	logic             push, pop;

	always_comb begin
		in_ready_o  = count_reg != CNT_FULL;
		out_valid_o = count_reg != '0;
		out_data_o  = store[rd_ptr_reg];
		push        = in_valid_i && in_ready_o;
		pop         = out_valid_o && out_ready_i;
		wr_ptr_next = push ? ((wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1) : wr_ptr_reg;
		rd_ptr_next = pop ? ((rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1) : rd_ptr_reg;
		count_next  = count_reg + CW'(push) - CW'(pop);
	end

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			wr_ptr_reg <= wr_ptr_next;
			rd_ptr_reg <= rd_ptr_next;
			count_reg  <= count_next;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			store[wr_ptr_reg] <= in_data_i;
		end
	end
endmodule : write_fifo
`default_nettype wire

// ### testbench/bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module bus_master_model
	import sram_ctrl_pkg::*;
(
	input  wire logic         core_clk_i,
	output logic [ADDR_W-1:0] addr_o,
	output logic              proc_addr_strobe_n_o,
	output logic              ctrl_addr_strobe_n_o,
	output logic              chip_sel_first_n_o,
	output logic              chip_sel_second_hi_o,
	output logic              chip_sel_third_n_o,
	output logic              burst_advance_n_o,
	output logic              global_write_n_o,
	output logic              byte_write_enable_n_o,
	output logic              lane_a_write_n_o,
	output logic              lane_b_write_n_o,
	output logic              lane_c_write_n_o,
	output logic              lane_d_write_n_o,
	output logic              output_enable_n_o,
	output logic              burst_order_o,
	output logic              sleep_request_o,
	output logic [DATA_W-1:0] dq_o
);
	initial begin
		addr_o            = '0;
		{proc_addr_strobe_n_o, ctrl_addr_strobe_n_o} = 2'h3;
		{chip_sel_first_n_o, chip_sel_second_hi_o, chip_sel_third_n_o} = 3'h5;
		burst_advance_n_o = 1'b1;
		{global_write_n_o, byte_write_enable_n_o, lane_d_write_n_o, lane_c_write_n_o,
			lane_b_write_n_o, lane_a_write_n_o} = 6'h3F;
		{output_enable_n_o, burst_order_o, sleep_request_o} = 3'h0;
		dq_o              = '0;
	end

	// One bus cycle, launched after an edge and held to the next
	task automatic cyc(input logic [1:0] strb, input logic [ADDR_W-1:0] a,
		input logic [2:0] ce, input logic burst_advance_n, input logic [5:0] wr,
		input logic [DATA_W-1:0] d);
		@(posedge core_clk_i);
		{proc_addr_strobe_n_o, ctrl_addr_strobe_n_o} <= strb;
		addr_o            <= a;
		{chip_sel_first_n_o, chip_sel_second_hi_o, chip_sel_third_n_o} <= ce;
		burst_advance_n_o <= burst_advance_n;
		{global_write_n_o, byte_write_enable_n_o, lane_d_write_n_o, lane_c_write_n_o,
			lane_b_write_n_o, lane_a_write_n_o} <= wr;
		// Released data bus shows inverted last value
		dq_o              <= (wr[5] && wr[4]) ? ~dq_o : d;
	endtask : cyc

	task automatic rest(input int n);
		repeat (n) cyc(2'h3, '0, 3'h5, 1'b1, 6'h3F, '0);
	endtask : rest

	task automatic set_async(input logic [2:0] v);
		@(posedge core_clk_i);
		{output_enable_n_o, burst_order_o, sleep_request_o} <= v;
	endtask : set_async
endmodule : bus_master_model
`default_nettype wire

// ### testbench/test_pipelined_burst_sram_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_pipelined_burst_sram_control
	import sram_ctrl_pkg::*;
;
	localparam logic [1:0] PROC = 2'h1, CTRL = 2'h2, NONE = 2'h3, BOTH = 2'h0;
	localparam logic [2:0] CE_ON = 3'h2, NO_SEC = 3'h0, NO_THIRD = 3'h3, NO_FIRST = 3'h6;
	localparam logic [5:0] RD = 6'h3F, GW = 6'h1F, LANE_A = 6'h2E, LANE_CD = 6'h23;
	localparam logic [5:0] BWE_OFF = 6'h30, LANE_B = 6'h2D;
	localparam logic [ADDR_W-1:0] BASE = 17'h00104;

	logic              clk, resetn, burst_advance_n, dq_oe;
	logic              proc_n, ctrl_n, first_n, second_hi, third_n;
	logic              gw_n, bwe_n, lane_a_n, lane_b_n, lane_c_n, lane_d_n;
	logic              oe_n, order, sleep;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] dq_in, dq_out;
	logic [DATA_W-1:0] ref_m [4];
	logic [DATA_W-1:0] exp_q [$];
	logic [DATA_W-1:0] got_q [$];
	int                failures, check_count;

	bus_master_model master (.core_clk_i(clk), .addr_o(addr),
		.proc_addr_strobe_n_o(proc_n), .ctrl_addr_strobe_n_o(ctrl_n),
		.chip_sel_first_n_o(first_n), .chip_sel_second_hi_o(second_hi),
		.chip_sel_third_n_o(third_n), .burst_advance_n_o(burst_advance_n),
		.global_write_n_o(gw_n), .byte_write_enable_n_o(bwe_n),
		.lane_a_write_n_o(lane_a_n), .lane_b_write_n_o(lane_b_n),
		.lane_c_write_n_o(lane_c_n), .lane_d_write_n_o(lane_d_n),
		.output_enable_n_o(oe_n), .burst_order_o(order),
		.sleep_request_o(sleep), .dq_o(dq_in));

	burst_sram_ctrl dut (.core_clk_i(clk), .resetn_i(resetn), .addr_i(addr),
		.proc_addr_strobe_n_i(proc_n), .ctrl_addr_strobe_n_i(ctrl_n),
		.burst_advance_n_i(burst_advance_n), .chip_sel_first_n_i(first_n),
		.chip_sel_second_hi_i(second_hi), .chip_sel_third_n_i(third_n),
		.global_write_n_i(gw_n), .byte_write_enable_n_i(bwe_n),
		.lane_a_write_n_i(lane_a_n), .lane_b_write_n_i(lane_b_n),
		.lane_c_write_n_i(lane_c_n), .lane_d_write_n_i(lane_d_n),
		.output_enable_n_i(oe_n), .burst_order_i(order),
		.sleep_request_i(sleep), .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	always @(negedge clk) if (dq_oe === 1'b1) got_q.push_back(dq_out);

	task automatic chk(input string name, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, e, g);
		end
	endtask : chk

	task automatic cmp_q(input string name);
		chk({name, " count"}, 32'(exp_q.size()), 32'(got_q.size()));
		for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) chk(name, exp_q[i], got_q[i]);
		exp_q.delete();
	endtask : cmp_q

	// Reads with all three strobe forms; write controls on a processor start are ignored
	task automatic read_all(input string name);
		master.cyc(CTRL, BASE, NO_SEC, 1'b1, RD, '0);
		master.rest(2);
		got_q.delete();
		for (int i = 0; i < 4; i++) begin
			exp_q.push_back(ref_m[i]);
			master.cyc(i == 1 ? PROC : i == 2 ? BOTH : CTRL, BASE + 17'(i), CE_ON, 1'b1,
				(i == 0 || i == 3) ? RD : GW, 32'hDEADBEEF);
		end
		// Wait beat repeats the last word; the deselect then cancels that repeat
		master.cyc(NONE, BASE, CE_ON, 1'b1, RD, '0);
		master.cyc(CTRL, BASE, NO_SEC, 1'b1, RD, '0);
		master.rest(4);
		cmp_q(name);
	endtask : read_all

	task automatic full_writes();
		for (int i = 0; i < 4; i++) begin
			ref_m[i] = 32'hC0DE0000 + 32'(i);
			master.cyc(CTRL, BASE + 17'(i), CE_ON, 1'b0, GW, ref_m[i]);
		end
		read_all("full write");
	endtask : full_writes

	task automatic byte_writes();
		master.cyc(CTRL, BASE, CE_ON, 1'b1, LANE_A, 32'h55555555);
		master.cyc(CTRL, BASE + 17'h1, CE_ON, 1'b1, LANE_CD, 32'h12345678);
		master.cyc(CTRL, BASE + 17'h3, CE_ON, 1'b1, LANE_B, 32'hAAAAAAAA);
		master.cyc(CTRL, BASE + 17'h2, CE_ON, 1'b1, BWE_OFF, 32'hFFFFFFFF);
		ref_m[0] = 32'hC0DE0055;
		ref_m[1] = 32'h12340001;
		ref_m[3] = 32'hC0DEAA03;
		read_all("byte write");
	endtask : byte_writes

	task automatic proc_write_and_refusals();
		master.cyc(PROC, BASE + 17'h3, CE_ON, 1'b0, LANE_A, 32'h0);
		master.cyc(NONE, BASE, CE_ON, 1'b1, GW, 32'h89ABCDEF);
		ref_m[3] = 32'h89ABCDEF;
		master.cyc(CTRL, BASE + 17'h1, NO_THIRD, 1'b1, GW, 32'h0);
		master.cyc(CTRL, BASE + 17'h2, NO_SEC, 1'b1, GW, 32'h0);
		master.cyc(PROC, BASE, NO_FIRST, 1'b1, RD, 32'h0);
		master.cyc(NONE, BASE, NO_FIRST, 1'b1, GW, 32'h0);
		read_all("refused access");
	endtask : proc_write_and_refusals

	task automatic bursts();
		int seq [5] = '{0, 1, 1, 2, 3};
		for (int ord = 0; ord < 2; ord++) begin
			master.set_async({1'b0, ord[0], 1'b0});
			master.rest(3);
			got_q.delete();
			for (int j = 0; j < 5; j++) begin
				exp_q.push_back(ref_m[ord ? (2 ^ seq[j]) : ((2 + seq[j]) % 4)]);
				master.cyc(j == 0 ? CTRL : NONE, BASE + 17'h2, CE_ON, j == 2, RD, '0);
			end
			master.cyc(NONE, BASE, CE_ON, 1'b1, RD, '0);
			master.cyc(CTRL, BASE, NO_SEC, 1'b1, RD, '0);
			master.rest(3);
			cmp_q(ord ? "interleaved burst" : "linear burst");
		end
	endtask : bursts

	task automatic oe_and_sleep();
		master.cyc(CTRL, BASE + 17'h1, CE_ON, 1'b1, RD, '0);
		repeat (3) master.cyc(NONE, BASE, CE_ON, 1'b1, RD, '0);
		#1 chk("read data", ref_m[1], dq_out);
		master.set_async(3'h4);
		#1 chk("drive oe off", 32'h0, {31'h0, dq_oe});
		master.set_async(3'h0);
		#1 chk("drive oe on", 32'h1, {31'h0, dq_oe});
		master.set_async(3'h1);
		master.rest(4);
		#1 chk("drive asleep", 32'h0, {31'h0, dq_oe});
		master.set_async(3'h0);
		master.rest(4);
		read_all("after sleep");
	endtask : oe_and_sleep

	task automatic print_verdict();
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict

	initial begin
		failures    = 0;
		check_count = 0;
		resetn      = 1'b0;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		full_writes();
		byte_writes();
		proc_write_and_refusals();
		bursts();
		oe_and_sleep();
		print_verdict();
	end

	initial begin
		#40000;
		failures++;
		print_verdict();
	end
endmodule : test_pipelined_burst_sram_control
`default_nettype wire
